// ---- design/pmes_pkg.sv ----
// Package: register map, field layout and carriers of the primary mode and error status block
package pmes_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [3:0] PMES_ADDR_STATUS2 = 4'h2;
	localparam logic [3:0] PMES_ADDR_ERROR   = 4'h3;

	////////////////////////////////////////////////////////////////////////////
	// Field positions shared by both registers
	localparam int PMES_BIT_PARITY = 0;
	localparam int PMES_BIT_LMI    = 1;

	// Mode and pin status register fields
	localparam int PMES_BIT_ENABLE_VALID  = 2;
	localparam int PMES_BIT_FAULT_PIN_A_REQUEST   = 3;
	localparam int PMES_BIT_FAULT_PIN_B_REQUEST   = 4;
	localparam int PMES_BIT_MODE   = 5;
	localparam int PMES_BIT_CLSA   = 8;
	localparam int PMES_BIT_CLSB   = 9;
	localparam int PMES_BIT_STPINH = 10;
	localparam int PMES_BIT_ADCV   = 11;

	////////////////////////////////////////////////////////////////////////////
	// Error flag vector: index into the sticky cells
	localparam int PMES_NERR   = 7;
	localparam int PMES_E_COMM = 0;
	localparam int PMES_E_ADC  = 1;
	localparam int PMES_E_SPI  = 2;
	localparam int PMES_E_STP  = 3;
	localparam int PMES_E_EN   = 4;
	localparam int PMES_E_RST  = 5;
	localparam int PMES_E_EXT  = 6;

	// Register bit of each error flag, by index
	localparam int PMES_ERR_POS [PMES_NERR] = '{2, 6, 8, 9, 10, 11, 12};

	////////////////////////////////////////////////////////////////////////////
	// Values after reset, and the reserved mode code
	localparam logic [PMES_NERR-1:0] PMES_ERR_RST  = 7'h20;
	localparam logic [1:0]           PMES_FLT_RST  = 2'h0;
	localparam logic [2:0]           PMES_MODE_RST = 3'h0;
	localparam logic [2:0]           PMES_MODE_RES = 3'h7;

	////////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic [2:0] mode;
		logic       flt_a;
		logic       flt_b;
		logic       en_valid;
		logic       stp_inh;
		logic       adc_under;
		logic       adc_over;
		logic       cls_a;
		logic       cls_b;
		logic       sec_ready;
	} pmes_stat_in_t;

	typedef struct packed {
		logic stp_err;
		logic spi_err;
		logic comm_loss;
		logic msg_done;
		logic msg_bad;
	} pmes_evt_t;

	typedef struct packed {
		logic       req;
		logic [3:0] addr;
	} pmes_rd_t;

	typedef struct packed {
		logic        req;
		logic [3:0]  addr;
		logic [15:0] mask;
	} pmes_clr_t;

endpackage : pmes_pkg

// ---- design/pmes_sticky_bits.sv ----
// Bank of sticky flag cells with set priority and clear blocking
module pmes_sticky_bits #(
	parameter int             W       = 1,
	parameter logic [W-1:0]   RST_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] set_i,
	input  wire logic [W-1:0] clr_i,
	input  wire logic [W-1:0] blk_i,
	output logic      [W-1:0] q_ff
);
	logic [W-1:0] nxt_q;

	////////////////////////////////////////////////////////////////////////////
	// Set beats clear; a blocked clear leaves the flag standing
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_cell
			assign nxt_q[i] = set_i[i] | (q_ff[i] & ~(clr_i[i] & ~blk_i[i]));
		end
	endgenerate

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q_ff <= RST_VAL;
		end else begin
			q_ff <= nxt_q;
		end
	end

endmodule : pmes_sticky_bits

// ---- design/pmes_status.sv ----
// Primary mode, pin status and sticky error register bank
module pmes_status (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic                    reset_ready_pin_n,
	input  wire pmes_pkg::pmes_stat_in_t stat_i,
	input  wire pmes_pkg::pmes_evt_t     evt_i,
	input  wire pmes_pkg::pmes_rd_t      rd_i,
	input  wire pmes_pkg::pmes_clr_t     clr_i,
	output logic [15:0]                  rd_data_ff,
	output logic                         rd_valid_ff,
	output logic                         err_summary,
	output logic                         fault_out_a_n_o,
	output logic                         fault_out_a_n_oe,
	output logic                         fault_out_b_n_o,
	output logic                         fault_out_b_n_oe
);
	import pmes_pkg::*;

	logic                 pin_meta_ff;
	logic                 pin_sync_ff;
	logic                 pin_prev_ff;
	logic                 nxt_pin_prev;
	logic                 en_prev_ff;
	logic                 nxt_en_prev;
	logic [2:0]           mode_ff;
	logic [2:0]           nxt_mode;
	logic                 lmi_ff;
	logic                 nxt_lmi;
	logic                 ext_evt;
	logic                 en_fall;
	logic                 adc_viol;
	logic [PMES_NERR-1:0] err_set;
	logic [PMES_NERR-1:0] err_clr;
	logic [PMES_NERR-1:0] err_blk;
	logic [PMES_NERR-1:0] err_q;
	logic [1:0]           flt_clr;
	logic [1:0]           flt_q;
	logic [15:0]          stat_word;
	logic [15:0]          err_word;
	logic [15:0]          nxt_rd_data;
	logic                 nxt_rd_valid;
	logic                 clr_stat;
	logic                 clr_err;

	////////////////////////////////////////////////////////////////////////////
	// Reset/ready pin: two-stage synchroniser, falling edge is the event
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_meta_ff <= 1'b1;
			pin_sync_ff <= 1'b1;
		end else begin
			pin_meta_ff <= reset_ready_pin_n;
			pin_sync_ff <= pin_meta_ff;
		end
	end

	always_comb begin
		nxt_pin_prev = pin_sync_ff;
		nxt_en_prev  = stat_i.en_valid;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_prev_ff <= 1'b1;
			en_prev_ff  <= 1'b0;
		end else begin
			pin_prev_ff <= nxt_pin_prev;
			en_prev_ff  <= nxt_en_prev;
		end
	end

	assign ext_evt  = pin_prev_ff & ~pin_sync_ff;
	assign en_fall  = en_prev_ff & ~stat_i.en_valid;
	assign adc_viol = stat_i.adc_under | stat_i.adc_over;

	////////////////////////////////////////////////////////////////////////////
	// Mode code and last-message state
	always_comb begin
		nxt_mode = mode_ff;
		if (stat_i.mode != PMES_MODE_RES) begin
			nxt_mode = stat_i.mode;
		end
		nxt_lmi = lmi_ff;
		if (evt_i.msg_done) begin
			nxt_lmi = evt_i.msg_bad;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_ff <= PMES_MODE_RST;
			lmi_ff  <= 1'b0;
		end else begin
			mode_ff <= nxt_mode;
			lmi_ff  <= nxt_lmi;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sticky error flags
	assign clr_err  = clr_i.req && (clr_i.addr == PMES_ADDR_ERROR);
	assign clr_stat = clr_i.req && (clr_i.addr == PMES_ADDR_STATUS2);

	always_comb begin
		err_set              = '0;
		err_set[PMES_E_EXT]  = ext_evt;
		err_set[PMES_E_RST]  = ext_evt;
		err_set[PMES_E_EN]   = en_fall;
		err_set[PMES_E_STP]  = evt_i.stp_err;
		err_set[PMES_E_SPI]  = evt_i.spi_err;
		err_set[PMES_E_ADC]  = adc_viol;
		err_set[PMES_E_COMM] = evt_i.comm_loss;
		err_blk              = '0;
		err_blk[PMES_E_STP]  = stat_i.stp_inh;
		err_blk[PMES_E_ADC]  = adc_viol;
		err_blk[PMES_E_COMM] = ~stat_i.sec_ready;
		for (int k = 0; k < PMES_NERR; k++) begin
			err_clr[k] = clr_err & clr_i.mask[PMES_ERR_POS[k]];
		end
	end

	pmes_sticky_bits #(
		.W       (PMES_NERR),
		.RST_VAL (PMES_ERR_RST)
	) u_err (
		.clk   (clk),
		.rst   (rst),
		.set_i (err_set),
		.clr_i (err_clr),
		.blk_i (err_blk),
		.q_ff  (err_q)
	);

	////////////////////////////////////////////////////////////////////////////
	// Sticky fault pin request copies; a live request blocks its clear
	assign flt_clr = {clr_stat & clr_i.mask[PMES_BIT_FAULT_PIN_B_REQUEST],
		clr_stat & clr_i.mask[PMES_BIT_FAULT_PIN_A_REQUEST]};

	pmes_sticky_bits #(
		.W       (2),
		.RST_VAL (PMES_FLT_RST)
	) u_flt (
		.clk   (clk),
		.rst   (rst),
		.set_i ({stat_i.flt_b, stat_i.flt_a}),
		.clr_i (flt_clr),
		.blk_i ({stat_i.flt_b, stat_i.flt_a}),
		.q_ff  (flt_q)
	);

	// Open-drain fault pins pull low while requested
	assign fault_out_a_n_o  = 1'b0;
	assign fault_out_a_n_oe = stat_i.flt_a;
	assign fault_out_b_n_o  = 1'b0;
	assign fault_out_b_n_oe = stat_i.flt_b;

	assign err_summary = |err_q;

	////////////////////////////////////////////////////////////////////////////
	// Register words and read port
	always_comb begin
		stat_word                      = '0;
		stat_word[PMES_BIT_ADCV]       = adc_viol;
		stat_word[PMES_BIT_STPINH]     = stat_i.stp_inh;
		stat_word[PMES_BIT_CLSB]       = stat_i.cls_b;
		stat_word[PMES_BIT_CLSA]       = stat_i.cls_a;
		stat_word[PMES_BIT_MODE +: 3]  = mode_ff;
		stat_word[PMES_BIT_FAULT_PIN_B_REQUEST]       = flt_q[1];
		stat_word[PMES_BIT_FAULT_PIN_A_REQUEST]       = flt_q[0];
		stat_word[PMES_BIT_ENABLE_VALID]      = stat_i.en_valid;
		stat_word[PMES_BIT_LMI]        = lmi_ff;
		stat_word[PMES_BIT_PARITY]     = ~^stat_word[15:1];
		err_word                       = '0;
		for (int k = 0; k < PMES_NERR; k++) begin
			err_word[PMES_ERR_POS[k]] = err_q[k];
		end
		err_word[PMES_BIT_LMI]         = lmi_ff;
		err_word[PMES_BIT_PARITY]      = ~^err_word[15:1];
		nxt_rd_valid = rd_i.req;
		nxt_rd_data  = rd_data_ff;
		if (rd_i.req) begin
			case (rd_i.addr)
				PMES_ADDR_STATUS2: nxt_rd_data = stat_word;
				PMES_ADDR_ERROR:   nxt_rd_data = err_word;
				default:           nxt_rd_data = '0;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_data_ff  <= '0;
			rd_valid_ff <= 1'b0;
		end else begin
			rd_data_ff  <= nxt_rd_data;
			rd_valid_ff <= nxt_rd_valid;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_pin_fall;
		$fell(pin_sync_ff);
	endsequence

	sequence s_rd_stat;
		rd_i.req && rd_i.addr == PMES_ADDR_STATUS2;
	endsequence

	sequence s_rd_err;
		rd_i.req && rd_i.addr == PMES_ADDR_ERROR;
	endsequence

	sequence s_msg_then_idle;
		evt_i.msg_done ##1 !evt_i.msg_done [*2];
	endsequence

	a_mode_no_res: assert property (
		mode_ff != PMES_MODE_RES)
		else $error("mode field holds reserved code");

	a_mode_tracks: assert property (
		!rst && stat_i.mode != PMES_MODE_RES |=> mode_ff == $past(stat_i.mode))
		else $error("mode field does not follow active mode");

	a_fault_pin_a_request_sticky: assert property (
		stat_i.flt_a ##1 !(clr_stat && clr_i.mask[PMES_BIT_FAULT_PIN_A_REQUEST])
		|=> flt_q[0])
		else $error("fault A copy lost without clear");

	a_fault_pin_b_request_sticky: assert property (
		stat_i.flt_b |=> flt_q[1] [*1] ##1 (flt_q[1] || $past(clr_stat)))
		else $error("fault B copy not held");

	a_parity_odd: assert property (
		rd_valid_ff && ($past(rd_i.addr) == PMES_ADDR_STATUS2
		|| $past(rd_i.addr) == PMES_ADDR_ERROR) |-> ^rd_data_ff == 1'b1)
		else $error("read word parity not odd");

	a_lmi_read: assert property (
		s_msg_then_idle ##0 (s_rd_err or s_rd_stat)
		|=> rd_data_ff[PMES_BIT_LMI] == $past(lmi_ff) && lmi_ff == $past(evt_i.msg_bad, 3))
		else $error("last message bit wrong on read");

	a_ext_rst_flags: assert property (
		s_pin_fall |=> err_q[PMES_E_EXT] && err_q[PMES_E_RST])
		else $error("pin reset did not set both reset flags");

	a_en_fall_flag: assert property (
		en_prev_ff && !stat_i.en_valid |=> err_q[PMES_E_EN])
		else $error("enable invalid flag not set");

	a_event_flags: assert property (
		evt_i.stp_err || evt_i.spi_err || evt_i.comm_loss
		|=> (err_q[PMES_E_STP] || !$past(evt_i.stp_err))
		&& (err_q[PMES_E_SPI] || !$past(evt_i.spi_err))
		&& (err_q[PMES_E_COMM] || !$past(evt_i.comm_loss)))
		else $error("event flag not set");

	a_stp_blocked: assert property (
		err_q[PMES_E_STP] && stat_i.stp_inh |=> err_q[PMES_E_STP])
		else $error("shoot-through flag cleared during inhibition");

	a_adc_blocked: assert property (
		adc_viol |=> err_q[PMES_E_ADC])
		else $error("ADC boundary flag missing during violation");

	a_comm_blocked: assert property (
		err_q[PMES_E_COMM] && !stat_i.sec_ready |=> err_q[PMES_E_COMM])
		else $error("comm loss flag cleared while secondary not ready");

	a_summary_or: assert property (
		err_summary == (err_word[12:2] != '0))
		else $error("error summary does not match flags");

	a_stat_live: assert property (
		s_rd_stat |=> rd_data_ff[PMES_BIT_ENABLE_VALID] == $past(stat_i.en_valid)
		&& rd_data_ff[PMES_BIT_ADCV] == $past(stat_i.adc_under || stat_i.adc_over)
		&& rd_data_ff[PMES_BIT_STPINH] == $past(stat_i.stp_inh))
		else $error("live status bits wrong on read");

	a_sticky_hold: assert property (
		err_q[PMES_E_SPI] && !clr_err |=> err_q[PMES_E_SPI])
		else $error("serial error flag dropped without clear");

endmodule : pmes_status

// ---- tb/pmes_host.sv ----
// Host model: register reads and write-one-to-clear requests toward the status block
module pmes_host (
	input  wire logic           clk,
	input  wire logic [15:0]    rd_data,
	input  wire logic           rd_valid,
	output pmes_pkg::pmes_rd_t  rd_o,
	output pmes_pkg::pmes_clr_t clr_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import pmes_pkg::*;

	initial begin
		rd_o = '0;
		clr_o = '0;
	end

	// Request held one cycle; answer taken 1 ns after the sampling edge
	task automatic read(input logic [3:0] a, output logic [15:0] d, output logic v);
		@(posedge clk);
		rd_o <= '{1'b1, a};
		@(posedge clk);
		rd_o <= '0;
		#1;
		v = rd_valid;
		d = rd_data;
	endtask : read

	task automatic clear(input logic [3:0] a, input logic [15:0] m);
		@(posedge clk);
		clr_o <= '{1'b1, a, m};
		@(posedge clk);
		clr_o <= '0;
	endtask : clear
endmodule : pmes_host

// ---- tb/primary_mode_error_status_bench.sv ----
// Self-checking bench of the primary mode and error status block
module primary_mode_error_status_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import pmes_pkg::*;

	typedef struct packed {
		pmes_stat_in_t st;
		logic [15:0]   exp;
	} pmes_row_t;

	logic          clk = 1'b0;
	logic          rst = 1'b1;
	logic          pin_n = 1'b1;
	pmes_stat_in_t stat;
	pmes_evt_t     evt = '0;
	pmes_rd_t      rd;
	pmes_clr_t     clr;
	logic [15:0]   rd_data;
	logic          rd_valid;
	logic          err_sum;
	logic          fa_o;
	logic          fa_oe;
	logic          fb_o;
	logic          fb_oe;
	logic [15:0]   d;
	logic          v;
	pmes_stat_in_t s;
	pmes_row_t     rows [8];
	int            mismatches = 0;
	int            num_checks = 0;
	int            cycles = 0;

	always #50 clk = ~clk;

	pmes_status uut (
		.clk              (clk),
		.rst              (rst),
		.reset_ready_pin_n(pin_n),
		.stat_i           (stat),
		.evt_i            (evt),
		.rd_i             (rd),
		.clr_i            (clr),
		.rd_data_ff       (rd_data),
		.rd_valid_ff      (rd_valid),
		.err_summary      (err_sum),
		.fault_out_a_n_o  (fa_o),
		.fault_out_a_n_oe (fa_oe),
		.fault_out_b_n_o  (fb_o),
		.fault_out_b_n_oe (fb_oe)
	);

	pmes_host host (
		.clk     (clk),
		.rd_data (rd_data),
		.rd_valid(rd_valid),
		.rd_o    (rd),
		.clr_o   (clr)
	);

	////////////////////////////////////////////////////////////////////////////
	// Flags: stp_inh, adc_under, adc_over, cls_a, cls_b from msb
	function automatic pmes_stat_in_t st(logic [2:0] m, logic [4:0] f);
		st = '0;
		st.mode = m;
		st.en_valid = 1'b1;
		st.sec_ready = 1'b1;
		{st.stp_inh, st.adc_under, st.adc_over, st.cls_a, st.cls_b} = f;
	endfunction : st

	function automatic logic [15:0] par(logic [15:0] w);
		par = {w[15:1], ~^w[15:1]};
	endfunction : par

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
		host.read(a, d, v);
		if (v !== 1'b1) begin
			d = 'x;
		end
		check(d, e);
	endtask : rdchk

	task automatic pulse(input pmes_evt_t e);
		@(posedge clk);
		evt <= e;
		@(posedge clk);
		evt <= '0;
	endtask : pulse

	// Flag set while its blocker stands: clear refused, then accepted once lifted
	task automatic blk(input pmes_stat_in_t bad, input pmes_evt_t e, input logic [15:0] b);
		@(posedge clk);
		stat <= bad;
		pulse(e);
		host.clear(PMES_ADDR_ERROR, b);
		rdchk(PMES_ADDR_ERROR, par(b));
		@(posedge clk);
		stat <= st(3'h6, 5'h00);
		host.clear(PMES_ADDR_ERROR, b);
		rdchk(PMES_ADDR_ERROR, par(16'h0000));
	endtask : blk

	task automatic results();
		$display("Checks %0d, mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : results

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			mismatches++;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		stat = st(3'h0, 5'h00);
		rows = '{'{st(3'h0, 5'h00), 16'h0004}, '{st(3'h1, 5'h08), 16'h0824},
			'{st(3'h2, 5'h04), 16'h0844}, '{st(3'h3, 5'h10), 16'h0464},
			'{st(3'h4, 5'h02), 16'h0184}, '{st(3'h5, 5'h01), 16'h02a4},
			'{st(3'h6, 5'h1b), 16'h0fc4}, '{st(3'h7, 5'h00), 16'h00c4}};
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rdchk(PMES_ADDR_ERROR, par(16'h0800));
		check({15'h0, err_sum}, 16'h0001);
		host.clear(PMES_ADDR_ERROR, 16'h0800);
		rdchk(PMES_ADDR_ERROR, par(16'h0000));
		check({15'h0, err_sum}, 16'h0000);
		foreach (rows[i]) begin
			@(posedge clk);
			stat <= rows[i].st;
			rdchk(PMES_ADDR_STATUS2, par(rows[i].exp));
		end
		rdchk(PMES_ADDR_ERROR, par(16'h0040));
		host.clear(PMES_ADDR_ERROR, 16'hffff);
		for (int i = 0; i < 3; i++) begin
			pulse(pmes_evt_t'(5'h10 >> i));
			rdchk(PMES_ADDR_ERROR, par(i == 0 ? 16'h0200 : i == 1 ? 16'h0100 : 16'h0004));
			check({15'h0, err_sum}, 16'h0001);
			host.clear(PMES_ADDR_ERROR, 16'hffff);
		end
		@(posedge clk);
		stat.en_valid <= 1'b0;
		rdchk(PMES_ADDR_STATUS2, par(16'h00c0));
		rdchk(PMES_ADDR_ERROR, par(16'h0400));
		@(posedge clk);
		stat.en_valid <= 1'b1;
		host.clear(PMES_ADDR_ERROR, 16'h0400);
		blk(st(3'h6, 5'h10), pmes_evt_t'(5'h10), 16'h0200);
		blk(st(3'h6, 5'h04), pmes_evt_t'(5'h00), 16'h0040);
		s = st(3'h6, 5'h00);
		s.sec_ready = 1'b0;
		blk(s, pmes_evt_t'(5'h04), 16'h0004);
		@(posedge clk);
		stat.flt_a <= 1'b1;
		stat.flt_b <= 1'b1;
		@(posedge clk);
		#1;
		check({12'h0, fa_oe, fb_oe, fa_o, fb_o}, 16'h000c);
		@(posedge clk);
		stat.flt_a <= 1'b0;
		stat.flt_b <= 1'b0;
		rdchk(PMES_ADDR_STATUS2, par(16'h00dc));
		host.clear(PMES_ADDR_STATUS2, 16'h0018);
		rdchk(PMES_ADDR_STATUS2, par(16'h00c4));
		pulse(pmes_evt_t'(5'h03));
		rdchk(PMES_ADDR_ERROR, par(16'h0002));
		rdchk(PMES_ADDR_STATUS2, par(16'h00c6));
		pulse(pmes_evt_t'(5'h02));
		rdchk(PMES_ADDR_ERROR, par(16'h0000));
		@(posedge clk);
		pin_n <= 1'b0;
		repeat (5) @(posedge clk);
		pin_n <= 1'b1;
		rdchk(PMES_ADDR_ERROR, par(16'h1800));
		rdchk(4'h5, 16'h0000);
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		rdchk(PMES_ADDR_ERROR, par(16'h0800));
		results();
	end
endmodule : primary_mode_error_status_bench
